// ### hw/event_port_pkg.sv
// Shared constants and types of the event packet host port.
// Assumes a 40 MHz system clock; all timing counts derive from it.
package event_port_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_HZ        = 40000000;
  localparam int STUCK_SLOW_MS     = 100;
  localparam int STUCK_FAST_MS     = 50;
  localparam int INIT_STRETCH_MS   = 10;
  localparam int STUCK_SLOW_CYCLES = STUCK_SLOW_MS * (SYS_CLK_HZ / 1000);
  localparam int STUCK_FAST_CYCLES = STUCK_FAST_MS * (SYS_CLK_HZ / 1000);
  localparam int INIT_STRETCH_CYC  = INIT_STRETCH_MS * (SYS_CLK_HZ / 1000);
  localparam int CNT_W             = 22;
  localparam logic [1:0] STARTUP_WAIT = 2'h3;

  // ****************************************
  // Addressing and memory
  // ****************************************
  localparam logic [6:0] ADDR_BAND0 = 7'h20;
  localparam logic [6:0] ADDR_BAND1 = 7'h30;
  localparam logic [6:0] ADDR_BAND2 = 7'h40;
  localparam logic [6:0] ADDR_BAND3 = 7'h11;
  localparam int         LOC_W            = 10;
  localparam int         MEM_DEPTH        = 1024;
  localparam logic [9:0] STATUS_SIZE      = 10'h024;
  localparam logic [9:0] READ_PTR_LOC     = 10'h3FF;
  localparam logic [9:0] RESET_FLAG_LOC   = 10'h000;
  localparam logic [7:0] RESET_FLAG_VALUE = 8'h80;

  // ****************************************
  // Packets and queue
  // ****************************************
  localparam logic [7:0] NO_PACKET_HDR   = 8'hFF;
  localparam logic [2:0] PACKET_BYTES    = 3'h5;
  localparam logic [2:0] PTR_DATA_IDX    = 3'h2;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam int         EVENT_CLASSES   = 9;
  localparam int         FIFO_DEPTH      = 8;
  localparam int         FIFO_AW         = 3;
  localparam logic [3:0] FIFO_FULL_COUNT = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_ACK_ADR = 3'b010,
    ST_WR_BYTE = 3'b011,
    ST_WR_ACK  = 3'b100,
    ST_RD_BYTE = 3'b101,
    ST_RD_ACK  = 3'b110,
    ST_STRETCH = 3'b111
  } bus_state_t;

endpackage : event_port_pkg

// ### hw/bit_sync.sv
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherence is kept across bits.
`timescale 1ns/10ps
module bit_sync #(
  parameter int               WIDTH       = 2,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  logic             sys_clk,
  input  logic             reset,
  input  logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second one
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta     <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : bit_sync

// ### hw/event_packet_host_port.sv
// Two-wire slave port that hands status change packets to a host master.
// Assumes open-drain lines resolved outside and a digitised address band input.
//
// Notes on behaviour
// - Packets come from status changes, debug requests and the reset announce; pending line low while one waits.
// - A per-class event mask enables or disables packet generation.
// - Address select is sampled once after reset and then held.
// - Four bands give addresses 0x20, 0x30, 0x40, 0x11; middle bands allow fast mode.
// - A write starts with a two-byte location, low byte first, stored as pointer.
// - Further write bytes go to the pointer, which steps by one per byte.
// - Writing a location's upper bits to the read pointer queues a debug packet.
// - A debug packet's header equals the value written to the read pointer.
// - A debug packet may wait behind others; a second debug request written while it is still held for a full queue replaces it.
// - Packets are five bytes: location upper bits, then four data bytes.
// - A plain five-byte read returns the next queued packet.
// - A core write that changes an unmasked status byte creates a packet without a request.
// - Pending line goes high during a read, returns low after if more queued.
// - A read with nothing pending returns header 0xFF.
// - The port may hold the clock low when it needs more time.
// - A line stuck low 100 ms slow or 50 ms fast resets the port.
// - Dormant state ends on address match, reset, or low-power cycle write.
// - After reset the reset flag is set and a packet announces readiness.
// - The first read after reset may stretch the clock up to 10 ms.
`timescale 1ns/10ps
module event_packet_host_port
  import event_port_pkg::*;
#(
  parameter int STUCK_SLOW_LIMIT = event_port_pkg::STUCK_SLOW_CYCLES,
  parameter int STUCK_FAST_LIMIT = event_port_pkg::STUCK_FAST_CYCLES,
  parameter int INIT_STRETCH     = event_port_pkg::INIT_STRETCH_CYC
) (
  input  logic                                   sys_clk,
  input  logic                                   reset,
  input  logic                                   scl_in,
  output logic                                   scl_out,
  output logic                                   scl_oe_n,
  input  logic                                   sda_in,
  output logic                                   sda_out,
  output logic                                   sda_oe_n,
  input  logic [1:0]                             address_select_pin,
  input  logic [event_port_pkg::EVENT_CLASSES-1:0] event_mask,
  input  logic                                   status_wr_en,
  input  logic [event_port_pkg::LOC_W-1:0]        status_wr_addr,
  input  logic [7:0]                             status_wr_data,
  input  logic                                   enter_dormant,
  input  logic                                   low_power_cycle,
  output logic                                   pending_n,
  output logic                                   dormant,
  output logic                                   fast_mode
);
  import event_port_pkg::*;

  // ****************************************
  // Line sampling
  // ****************************************
  logic [1:0] bus_s;
  logic [1:0] band_s;
  logic [1:0] bus_q;

  bit_sync #(.WIDTH(2), .RESET_VALUE(2'h3)) u_bus_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .async_in({scl_in, sda_in}),
    .sync_out(bus_s)
  );

  bit_sync #(.WIDTH(2), .RESET_VALUE(2'h0)) u_band_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .async_in(address_select_pin),
    .sync_out(band_s)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) bus_q <= 2'h3;
    else bus_q <= bus_s;
  end

  wire scl_s    = bus_s[1];
  wire sda_s    = bus_s[0];
  wire scl_rise = scl_s & ~bus_q[1];
  wire scl_fall = ~scl_s & bus_q[1];
  wire start_c  = scl_s & bus_q[1] & ~sda_s & bus_q[0];
  wire stop_c   = scl_s & bus_q[1] & sda_s & ~bus_q[0];

  // ****************************************
  // Address strap and reset announce
  // ****************************************
  logic [1:0] startup_cnt;
  logic       addr_sampled;
  logic [6:0] slave_addr;

  // Wait for the band synchroniser to settle before the one-time capture
  wire       sample_now = ~addr_sampled & (startup_cnt == STARTUP_WAIT);
  wire [6:0] band_addr  = (band_s == 2'h0) ? ADDR_BAND0 :
                          (band_s == 2'h1) ? ADDR_BAND1 :
                          (band_s == 2'h2) ? ADDR_BAND2 : ADDR_BAND3;
  wire       band_fast  = (band_s == 2'h1) | (band_s == 2'h2);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      startup_cnt  <= 2'h0;
      addr_sampled <= 1'b0;
      slave_addr   <= ADDR_BAND0;
      fast_mode    <= 1'b0;
    end else if (!addr_sampled) begin
      startup_cnt <= startup_cnt + 2'h1;
      if (sample_now) begin
        addr_sampled <= 1'b1;
        slave_addr   <= band_addr;
        fast_mode    <= band_fast;
      end
    end
  end

  // ****************************************
  // Stuck line monitor
  // ****************************************
  logic [CNT_W-1:0] stuck_cnt;

  wire [CNT_W-1:0] stuck_limit = fast_mode ? CNT_W'(STUCK_FAST_LIMIT) : CNT_W'(STUCK_SLOW_LIMIT);
  wire             bus_stuck   = (stuck_cnt >= stuck_limit);

  always_ff @(posedge sys_clk) begin
    if (reset || bus_s == 2'h3 || bus_s != bus_q) stuck_cnt <= '0;
    else if (!bus_stuck) stuck_cnt <= stuck_cnt + CNT_W'(1);
  end

  // ****************************************
  // Status memory and packet queue
  // ****************************************
  logic [7:0]         status_mem [MEM_DEPTH];
  logic [7:0]         fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr;
  logic [FIFO_AW-1:0] rd_ptr;
  logic [3:0]         fifo_count;
  logic               forced_req;
  logic [7:0]         forced_hdr;

  bus_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic       rw;
  logic [2:0] byte_idx;
  logic [9:0] ptr;
  logic       reading;
  logic       first_read;
  logic [7:0] pkt_hdr;
  logic [CNT_W-1:0] stretch_cnt;
  logic       master_ack;

  wire fifo_full  = (fifo_count == FIFO_FULL_COUNT);
  wire fifo_empty = (fifo_count == 4'h0);
  wire quiet      = ~bus_stuck & ~start_c & ~stop_c;
  wire byte_done  = scl_fall & (bit_cnt == BITS_PER_BYTE);

  wire change_evt = status_wr_en & (status_wr_addr < STATUS_SIZE)
                  & (status_wr_data != status_mem[status_wr_addr])
                  & event_mask[status_wr_addr[5:2]];
  wire enq_forced = forced_req & ~sample_now;
  wire enq_change = change_evt & ~sample_now & ~forced_req;
  wire push       = (sample_now | enq_forced | enq_change) & ~fifo_full;
  wire [7:0] push_hdr = sample_now ? RESET_FLAG_LOC[9:2] :
                        enq_forced ? forced_hdr : status_wr_addr[9:2];

  wire [7:0] head_hdr = fifo_empty ? NO_PACKET_HDR : fifo_mem[rd_ptr];
  wire hdr_load  = quiet & ((state == ST_ACK_ADR & scl_fall & rw & ~first_read)
                 | (state == ST_STRETCH & stretch_cnt == '0));
  wire more_data = quiet & (state == ST_RD_ACK) & scl_fall & master_ack & (byte_idx != PACKET_BYTES);
  wire load_byte = hdr_load | more_data;
  wire pop       = hdr_load & ~fifo_empty;
  wire [9:0] data_loc  = {pkt_hdr, byte_idx[1:0] - 2'h1};
  wire [7:0] load_val  = hdr_load ? head_hdr : status_mem[data_loc];
  wire [3:0] next_count = fifo_count + {3'h0, push} - {3'h0, pop};

  wire addr_hit   = addr_sampled & (shreg[7:1] == slave_addr);
  wire addr_match = quiet & (state == ST_ADDR) & byte_done & addr_hit;
  wire bus_mem_wr = quiet & (state == ST_WR_BYTE) & byte_done & (byte_idx == PTR_DATA_IDX);
  wire forced_set = bus_mem_wr & (ptr == READ_PTR_LOC);

  // Bus writes land after core writes, so the bus wins a same-address clash
  always_ff @(posedge sys_clk) begin
    if (sample_now) status_mem[RESET_FLAG_LOC] <= RESET_FLAG_VALUE;
    else if (status_wr_en) status_mem[status_wr_addr] <= status_wr_data;
    if (bus_mem_wr) status_mem[ptr] <= shreg;
    if (push) fifo_mem[wr_ptr] <= push_hdr;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      fifo_count <= 4'h0;
      forced_req <= 1'b0;
      forced_hdr <= 8'h00;
    end else begin
      wr_ptr     <= wr_ptr + FIFO_AW'(push);
      rd_ptr     <= rd_ptr + FIFO_AW'(pop);
      fifo_count <= next_count;
      // A held request waits for room instead of being lost
      forced_req <= forced_set | (forced_req & ~(enq_forced & ~fifo_full));
      if (forced_set) forced_hdr <= shreg;
    end
  end

  // ****************************************
  // Bus state machine
  // ****************************************
  bus_state_t       next_state;
  logic [3:0]       next_bit_cnt;
  logic [7:0]       next_shreg;
  logic             next_rw;
  logic [2:0]       next_byte_idx;
  logic [9:0]       next_ptr;
  logic             next_reading;
  logic             next_first_read;
  logic [7:0]       next_pkt_hdr;
  logic [CNT_W-1:0] next_stretch_cnt;
  logic             next_master_ack;
  logic             next_sda_oe_n;
  logic             next_scl_oe_n;

  always_comb begin
    next_state       = state;
    next_bit_cnt     = bit_cnt;
    next_shreg       = shreg;
    next_rw          = rw;
    next_byte_idx    = byte_idx;
    next_ptr         = ptr;
    next_reading     = reading;
    next_first_read  = first_read;
    next_pkt_hdr     = pkt_hdr;
    next_stretch_cnt = stretch_cnt;
    next_master_ack  = master_ack;
    next_sda_oe_n    = sda_oe_n;
    next_scl_oe_n    = scl_oe_n;
    if (bus_stuck) begin
      next_state    = ST_IDLE;
      next_sda_oe_n = 1'b1;
      next_scl_oe_n = 1'b1;
      next_reading  = 1'b0;
    end else if (start_c || stop_c) begin
      next_state    = start_c ? ST_ADDR : ST_IDLE;
      next_bit_cnt  = 4'h0;
      next_sda_oe_n = 1'b1;
      next_reading  = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            next_shreg   = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (byte_done && state == ST_ADDR) begin
            next_state    = addr_hit ? ST_ACK_ADR : ST_IDLE;
            next_sda_oe_n = ~addr_hit;
            next_rw       = shreg[0];
          end else if (byte_done) begin
            next_state    = ST_WR_ACK;
            next_sda_oe_n = 1'b0;
            if (byte_idx == 3'h0) next_ptr[7:0] = shreg;
            else if (byte_idx == 3'h1) next_ptr[9:8] = shreg[1:0];
            else next_ptr = ptr + 10'h001;
            if (byte_idx != PTR_DATA_IDX) next_byte_idx = byte_idx + 3'h1;
          end
        end
        ST_ACK_ADR: begin
          if (scl_fall) begin
            next_bit_cnt  = 4'h0;
            next_byte_idx = 3'h0;
            next_sda_oe_n = 1'b1;
            if (!rw) next_state = ST_WR_BYTE;
            else if (first_read) begin
              next_state       = ST_STRETCH;
              next_scl_oe_n    = 1'b0;
              next_stretch_cnt = CNT_W'(INIT_STRETCH);
            end
          end
        end
        ST_STRETCH: begin
          if (stretch_cnt != '0) next_stretch_cnt = stretch_cnt - CNT_W'(1);
          else begin
            // Clock stays held one more cycle so header bit 7 settles before SCL rises
            next_first_read = 1'b0;
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            next_state    = ST_WR_BYTE;
            next_sda_oe_n = 1'b1;
            next_bit_cnt  = 4'h0;
          end
        end
        ST_RD_BYTE: begin
          if (!scl_oe_n) next_scl_oe_n = 1'b1;
          if (byte_done) begin
            next_state    = ST_RD_ACK;
            next_sda_oe_n = 1'b1;
          end else if (scl_fall) begin
            next_sda_oe_n = shreg[6];
            next_shreg    = {shreg[6:0], 1'b0};
            next_bit_cnt  = bit_cnt + 4'h1;
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) next_master_ack = ~sda_s;
          else if (scl_fall) next_state = ST_IDLE;
        end
        ST_IDLE: begin
        end
        default: next_state = ST_IDLE;
      endcase
      // Each byte leaves MSB first; the header pops the queue head
      if (load_byte) begin
        next_state    = ST_RD_BYTE;
        next_shreg    = load_val;
        next_sda_oe_n = load_val[7];
        next_bit_cnt  = 4'h1;
        next_byte_idx = byte_idx + 3'h1;
      end
      if (hdr_load) begin
        next_pkt_hdr  = head_hdr;
        next_reading  = 1'b1;
        next_byte_idx = 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state       <= ST_IDLE;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      rw          <= 1'b0;
      byte_idx    <= 3'h0;
      ptr         <= 10'h000;
      reading     <= 1'b0;
      first_read  <= 1'b1;
      pkt_hdr     <= 8'h00;
      stretch_cnt <= '0;
      master_ack  <= 1'b0;
      sda_oe_n    <= 1'b1;
      scl_oe_n    <= 1'b1;
    end else begin
      state       <= next_state;
      bit_cnt     <= next_bit_cnt;
      shreg       <= next_shreg;
      rw          <= next_rw;
      byte_idx    <= next_byte_idx;
      ptr         <= next_ptr;
      reading     <= next_reading;
      first_read  <= next_first_read;
      pkt_hdr     <= next_pkt_hdr;
      stretch_cnt <= next_stretch_cnt;
      master_ack  <= next_master_ack;
      sda_oe_n    <= next_sda_oe_n;
      scl_oe_n    <= next_scl_oe_n;
    end
  end

  // ****************************************
  // Pending line and dormant state
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pending_n <= 1'b1;
      dormant   <= 1'b0;
      scl_out   <= 1'b0;
      sda_out   <= 1'b0;
    end else begin
      pending_n <= ~((next_count != 4'h0) & ~next_reading);
      // Entry wins over a wake in the same cycle
      dormant   <= enter_dormant | (dormant & ~(addr_match | low_power_cycle));
      scl_out   <= 1'b0;
      sda_out   <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_pending_queue: assert property (@(posedge sys_clk) disable iff (reset)
    !pending_n |-> (fifo_count != 4'h0) && !reading)
    else $error("pending low with empty queue or during read");
  a_pending_read: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(reading) |-> pending_n)
    else $error("pending low while packet read");
  a_addr_held: assert property (@(posedge sys_clk) disable iff (reset)
    $past(addr_sampled) |-> $stable(slave_addr) && addr_sampled)
    else $error("slave address changed after capture");
  a_band_speed: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(addr_sampled) |-> fast_mode == (slave_addr == 7'h30 || slave_addr == 7'h40))
    else $error("fast mode does not match address band");
  a_empty_header: assert property (@(posedge sys_clk) disable iff (reset)
    hdr_load && fifo_empty |=> pkt_hdr == 8'hFF && shreg == 8'hFF && sda_oe_n)
    else $error("empty read header not 0xFF");
  a_stuck_reset: assert property (@(posedge sys_clk) disable iff (reset)
    bus_stuck |=> state == ST_IDLE && sda_oe_n && scl_oe_n)
    else $error("stuck bus did not reset port");
  a_ptr_step: assert property (@(posedge sys_clk) disable iff (reset)
    bus_mem_wr |=> ptr == $past(ptr) + 10'h001)
    else $error("write pointer did not step by one");
  a_forced_kept: assert property (@(posedge sys_clk) disable iff (reset)
    forced_req && !fifo_full && !forced_set |-> ##[1:2] !forced_req || forced_set)
    else $error("forced request not queued");
  a_wake_match: assert property (@(posedge sys_clk) disable iff (reset)
    (addr_match || low_power_cycle) && !enter_dormant |=> !dormant)
    else $error("dormant not left on wake");
  a_stretch_low: assert property (@(posedge sys_clk) disable iff (reset)
    state == ST_STRETCH && stretch_cnt != '0 |-> !scl_oe_n)
    else $error("clock not held during init stretch");
  a_forced_hdr: assert property (@(posedge sys_clk) disable iff (reset)
    forced_set |=> forced_hdr == $past(shreg) && forced_req)
    else $error("forced header differs from written value");

endmodule : event_packet_host_port

// ### verif/i2c_host_model.sv
// Host master model driving the two open-drain wires.
// Assumes the bench resolves each wire with a pull-up.
`timescale 1ns/10ps
module i2c_host_model (
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      scl_pull,
  output logic      sda_pull
);
  // ****************************************
  // Bus cycles
  // ****************************************
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // SDA moves mid-low and is read late in high, so slow sampling still sees it
  task automatic bit_io(input logic b, output logic seen);
    int n;
    n = 0;
    #50 sda_pull = ~b;
    #50 scl_pull = 1'b0;
    while (scl_line !== 1'b1 && n < 20000) begin
      #10 n++;
    end
    #100 seen = sda_line;
    scl_pull = 1'b1;
  endtask : bit_io
  task automatic byte_io(input logic [7:0] b, input logic mack, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
      r[i] = s;
    end
    bit_io(~mack, s);
    ack = ~s;
  endtask : byte_io
  task automatic start(input logic [6:0] dev, input logic rd, output logic ok);
    logic [7:0] r;
    sda_pull = 1'b1;
    #100 scl_pull = 1'b1;
    byte_io({dev, rd}, 1'b0, r, ok);
  endtask : start
  task automatic stop();
    #50 sda_pull = 1'b1;
    #50 scl_pull = 1'b0;
    #100 sda_pull = 1'b0;
    #100;
  endtask : stop
  task automatic write_loc(input logic [6:0] dev, input logic [9:0] loc, input logic [31:0] d, input int n,
                           output logic ok);
    logic [7:0] r;
    logic       a;
    start(dev, 1'b0, ok);
    byte_io(loc[7:0], 1'b0, r, a);
    byte_io({6'h00, loc[9:8]}, 1'b0, r, a);
    for (int i = 0; i < n; i++) byte_io(d[31-8*i -: 8], 1'b0, r, a);
    stop();
  endtask : write_loc
  task automatic read_pkt(input logic [6:0] dev, output logic [39:0] p, output logic ok);
    logic a;
    start(dev, 1'b1, ok);
    for (int i = 0; i < 5; i++) if (ok) byte_io(8'hFF, i < 4, p[39-8*i -: 8], a);
    stop();
  endtask : read_pkt
  // Stops clocking after the address so only the device's ACK holds SDA low
  task automatic hang(input logic [6:0] dev, output logic early, output logic late);
    logic [7:0] b;
    logic       s;
    b = {dev, 1'b0};
    sda_pull = 1'b1;
    #100 scl_pull = 1'b1;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    #50 sda_pull = 1'b0;
    #20000 early = sda_line;
    #10000 late = sda_line;
    stop();
  endtask : hang
endmodule : i2c_host_model

// ### verif/event_packet_host_port_tb_top.sv
// Bench top for the event packet host port.
// Assumes the host model on the wires; the core side is driven here.
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module event_packet_host_port_tb_top;
  import event_port_pkg::*;
  logic                     sys_clk, reset, scl_out, scl_oe_n, sda_out, sda_oe_n, scl_pull, sda_pull, ok;
  logic                     status_wr_en, enter_dormant, low_power_cycle, pending_n, dormant, fast_mode;
  logic [1:0]               address_select_pin;
  logic [EVENT_CLASSES-1:0] event_mask;
  logic [9:0]               status_wr_addr;
  logic [7:0]               status_wr_data;
  logic [39:0]              pkt;
  logic [7:0]               mirror [36];
  int                       miscompares, num_checks, cycles;
  wire                      scl_line = ~scl_pull & (scl_oe_n | scl_out);
  wire                      sda_line = ~sda_pull & (sda_oe_n | sda_out);
  always #12.5 sys_clk = ~sys_clk;
  // Short limits keep the run brief; still far above one SCL low phase
  event_packet_host_port #(.STUCK_SLOW_LIMIT(2000), .STUCK_FAST_LIMIT(1000), .INIT_STRETCH(50))
    u_event_packet_host_port (.sys_clk(sys_clk), .reset(reset), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .address_select_pin(address_select_pin), .event_mask(event_mask), .status_wr_en(status_wr_en),
    .status_wr_addr(status_wr_addr), .status_wr_data(status_wr_data), .enter_dormant(enter_dormant),
    .low_power_cycle(low_power_cycle), .pending_n(pending_n), .dormant(dormant), .fast_mode(fast_mode));
  i2c_host_model u_i2c_host_model (.scl_line(scl_line), .sda_line(sda_line), .scl_pull(scl_pull),
    .sda_pull(sda_pull));
  // ****************************************
  // Helpers and scenarios
  // ****************************************
  task automatic complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic core_wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    status_wr_en = 1'b1;
    status_wr_addr = a;
    status_wr_data = d;
    @(negedge sys_clk);
    status_wr_en = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask : core_wr
  task automatic rd(input logic [6:0] dev);
    u_i2c_host_model.read_pkt(dev, pkt, ok);
    if (ok && pkt[39:32] < 8'h09) for (int i = 0; i < 4; i++) mirror[{pkt[39:32], i[1:0]}] = pkt[31-8*i -: 8];
    repeat (4) @(negedge sys_clk);
  endtask : rd
  task automatic t_announce();
    int n;
    n = 0;
    while (pending_n !== 1'b0 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(pending_n, 1'b0)
    `CHK(fast_mode, 1'b1)
    rd(7'h30);
    `CHK(ok, 1'b1)
    `CHK(pkt[39:24], {8'h00, RESET_FLAG_VALUE})
    `CHK(pending_n, 1'b1)
    $display("announce done");
  endtask : t_announce
  task automatic t_events();
    // Bus writes seed known bytes without making packets
    u_i2c_host_model.write_loc(7'h30, 10'h010, 32'h0, 4, ok);
    u_i2c_host_model.write_loc(7'h30, 10'h014, 32'h0, 4, ok);
    event_mask = 9'h010;
    core_wr(10'h014, 8'h33);
    `CHK(pending_n, 1'b1)
    core_wr(10'h010, 8'h5A);
    core_wr(10'h010, 8'h5A);
    `CHK(pending_n, 1'b0)
    u_i2c_host_model.write_loc(7'h30, 10'h120, 32'hA1B2C3D4, 4, ok);
    `CHK(ok, 1'b1)
    u_i2c_host_model.write_loc(7'h30, READ_PTR_LOC, 32'h48000000, 1, ok);
    rd(7'h30);
    `CHK(pkt, 40'h045A000000)
    `CHK(mirror[16], 8'h5A)
    `CHK(pending_n, 1'b0)
    rd(7'h30);
    `CHK(pkt, 40'h48A1B2C3D4)
    `CHK(pending_n, 1'b1)
    $display("events done");
  endtask : t_events
  task automatic t_stuck();
    logic early, late;
    // Fast band limit here is 1000 cycles: ACK still held at 800, released by 1200
    u_i2c_host_model.hang(7'h30, early, late);
    `CHK(early, 1'b0)
    `CHK(late, 1'b1)
    $display("stuck monitor done");
  endtask : t_stuck
  task automatic t_addr_dormant();
    logic [20:0] bad;
    bad = {7'h20, 7'h40, 7'h11};
    @(negedge sys_clk) address_select_pin = 2'h0;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      rd(bad[7*i +: 7]);
      `CHK(ok, 1'b0)
    end
    `CHK(fast_mode, 1'b1)
    @(negedge sys_clk) enter_dormant = 1'b1;
    @(negedge sys_clk) enter_dormant = 1'b0;
    `CHK(dormant, 1'b1)
    rd(7'h30);
    `CHK(dormant, 1'b0)
    `CHK(pkt[39:32], NO_PACKET_HDR)
    @(negedge sys_clk) enter_dormant = 1'b1;
    @(negedge sys_clk) enter_dormant = 1'b0;
    low_power_cycle = 1'b1;
    @(negedge sys_clk) low_power_cycle = 1'b0;
    `CHK(dormant, 1'b0)
    $display("address and dormant done");
  endtask : t_addr_dormant
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    {sys_clk, status_wr_en, enter_dormant, low_power_cycle} = '0;
    {status_wr_addr, status_wr_data, event_mask} = '0;
    {miscompares, num_checks, cycles} = '0;
    reset = 1'b1;
    address_select_pin = 2'h1;
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    t_announce();
    t_events();
    t_stuck();
    t_addr_dormant();
    complete_run();
  end
endmodule : event_packet_host_port_tb_top
